/* File: cail_chk.sv */
`timescale 1ns/1ps
module cail_chk
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [2:0]  regAddr,
	input wire logic [7:0]  regWdata,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [7:0]  regRdata,
	input wire logic        firstCmpRaw,
	input wire logic        sleepMode,
	input wire logic        portAPin3Out,
	input wire logic        portAPin3Oe,
	input wire logic        cmpPowerOn,
	input wire logic        intRefSelect,
	input wire logic [1:0]  qPhase,
	input wire logic        vectorLoad,
	input wire logic [12:0] vectorAddr,
	input wire logic        pushReturn,
	input wire logic        wakeUp
);
	logic [2:0] modeR;
	logic       dir3R;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Shadow of mode and pin three direction, seen from bus writes
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			modeR <= 3'h0;
			dir3R <= 1'b1;
		end
		else if (regWr)
		begin
			if (regAddr == 3'h0)
				modeR <= regWdata[2:0];
			if (regAddr == 3'h4)
				dir3R <= regWdata[3];
		end
	chk_vec_addr: assert property (vectorLoad |-> vectorAddr == 13'h0004)
		else $error("vector address wrong");
	chk_vec_push: assert property (vectorLoad == pushReturn)
		else $error("push and vector apart");
	chk_vec_gap: assert property (vectorLoad |=> !vectorLoad [*8])
		else $error("vector repeated without return");
	chk_rd_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data outside its cycle");
	chk_q_step: assert property ($past(rst_n, 2) |-> qPhase == 2'($past(qPhase) + 2'h1))
		else $error("phase count skipped");
	chk_pin_raw: assert property (modeR == 3'h6 && $past(modeR) == 3'h6
		|-> portAPin3Out == $past(firstCmpRaw))
		else $error("pin three not comparator output");
	chk_pin_oe: assert property (modeR == 3'h6 && $past(modeR) == 3'h6
		|-> portAPin3Oe == !$past(dir3R))
		else $error("pin three enable ignores direction");
	chk_power_off: assert property ($past(modeR) == 3'h7 || $past(modeR) == 3'h0
		|-> !cmpPowerOn)
		else $error("comparators powered in off mode");
	chk_ref_sel: assert property (intRefSelect == ($past(modeR) == 3'h2))
		else $error("reference select wrong");
	chk_wake_sleep: assert property (wakeUp |-> $past(sleepMode))
		else $error("wake outside sleep");
endmodule

bind cail_top cail_chk cail_chk_i (.clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd,
	.regRdata, .firstCmpRaw, .sleepMode, .portAPin3Out, .portAPin3Oe, .cmpPowerOn,
	.intRefSelect, .qPhase, .vectorLoad, .vectorAddr, .pushReturn, .wakeUp);

/* File: cail_core_model.sv */
`timescale 1ns/1ps
// Core side: executes the service routine, then the return instruction
module cail_core_model
#(
	parameter int SVC = 30
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic vectorLoad,
	input  wire logic pushReturn,
	output logic      retFromIrq
);
	int cnt;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			cnt <= 0;
			retFromIrq <= 1'b0;
		end
		else
		begin
			retFromIrq <= (cnt == 1);
			if (vectorLoad && pushReturn)
				cnt <= SVC;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
endmodule

/* File: cail_defs.vh */
`ifndef CAIL_DEFS_VH
`define CAIL_DEFS_VH

// Register offsets on the plain register port
`define CAIL_OFS_CMP_CTRL  3'h0
`define CAIL_OFS_PER_FLAG  3'h1
`define CAIL_OFS_PER_EN    3'h2
`define CAIL_OFS_MAIN_IRQ  3'h3
`define CAIL_OFS_PA_DIR    3'h4

// Comparator control fields
`define CAIL_CMP_OUT2_BIT  7
`define CAIL_CMP_OUT1_BIT  6
`define CAIL_CMP_MODE_HI   2
`define CAIL_CMP_MODE_LO   0

// Comparator modes
`define CAIL_MODE_RESET    3'h0
`define CAIL_MODE_INTREF   3'h2
`define CAIL_MODE_PINOUT   3'h6
`define CAIL_MODE_OFF      3'h7

// Peripheral flag and enable position
`define CAIL_CMP_FLAG_BIT  6

// Main interrupt control fields
`define CAIL_GIE_BIT       7
`define CAIL_PERIPHERAL_IRQ_ENABLE_BIT      6
`define CAIL_T0IE_BIT      5
`define CAIL_EXTIE_BIT     4
`define CAIL_PBIE_BIT      3
`define CAIL_T0IF_BIT      2
`define CAIL_EXTIF_BIT     1
`define CAIL_PBIF_BIT      0

// Port A direction positions for pins three and four
`define CAIL_PA3_BIT       3
`define CAIL_PA4_BIT       4

// Reset values
`define CAIL_RST_CMP_MODE  3'h0
`define CAIL_RST_MAIN_IRQ  8'h00
`define CAIL_RST_PER_EN    8'h00
`define CAIL_RST_PA_DIR    8'hFF

// Vector and instruction cycle timing
`define CAIL_VECTOR_ADDR   13'h0004
`define CAIL_Q_LAST        2'h3

`endif

/* File: cail_sync.v */
`timescale 1ns/1ps
`include "cail_defs.vh"

// Two-stage synchroniser for the comparator outputs
module cail_sync
(
	input  wire       clk,
	input  wire       rst_n,
	input  wire [1:0] asyncIn,
	output wire [1:0] syncOut
);

	reg [1:0] stage1_r;
	reg [1:0] stage2_r;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1_r <= 2'h0;
			stage2_r <= 2'h0;
		end
		else
		begin
			stage1_r <= asyncIn;
			stage2_r <= stage1_r;
		end
	end

	assign syncOut = stage2_r;

endmodule

/* File: cail_top.v */
`timescale 1ns/1ps
`include "cail_defs.vh"

module cail_top
(
	input  wire        clk,
	input  wire        rst_n,
	input  wire [2:0]  regAddr,
	input  wire [7:0]  regWdata,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [7:0]  regRdata,
	input  wire        firstCmpRaw,
	input  wire        secondCmpRaw,
	input  wire        extIrqPin,
	input  wire        timerZeroOvf,
	input  wire [3:0]  portBChangePins,
	input  wire        portADataPin3,
	input  wire        portADataPin4,
	input  wire        sleepMode,
	input  wire        retFromIrq,
	output reg         portAPin3Out,
	output reg         portAPin3Oe,
	output reg         portAPin4Out,
	output reg         portAPin4Oe,
	output reg         cmpPowerOn,
	output reg         intRefSelect,
	output reg         allAnalog,
	output reg  [1:0]  qPhase,
	output reg         vectorLoad,
	output reg  [12:0] vectorAddr,
	output reg         pushReturn,
	output reg         forceNop,
	output reg         wakeUp
);

	localparam ST_IDLE  = 2'h0;
	localparam ST_WAIT1 = 2'h1;
	localparam ST_WAIT2 = 2'h2;

	wire [1:0] cmpSync;

	reg  [2:0] cmpMode_r;
	reg  [1:0] cmpLatch_r;
	reg        cmpFlag_r;
	reg        cmpEnable_r;
	reg  [7:0] mainIrq_r;
	reg  [1:0] paDir_r;
	reg        extPrev_r;
	reg  [3:0] pbPrev_r;
	reg  [1:0] qCnt_r;
	reg  [1:0] state_r;
	reg  [1:0] state_nxt;
	reg        gieClrPend_r;
	reg        gieDrop_r;
	reg  [7:0] mainIrq_nxt;
	reg        cmpFlag_nxt;
	reg  [7:0] rdMux;

	wire cycEnd = (qCnt_r == `CAIL_Q_LAST);
	wire wrCmp  = regWr && (regAddr == `CAIL_OFS_CMP_CTRL);
	wire rdCmp  = regRd && (regAddr == `CAIL_OFS_CMP_CTRL);
	wire wrFlag = regWr && (regAddr == `CAIL_OFS_PER_FLAG);
	wire wrEn   = regWr && (regAddr == `CAIL_OFS_PER_EN);
	wire wrMain = regWr && (regAddr == `CAIL_OFS_MAIN_IRQ);
	wire wrDir  = regWr && (regAddr == `CAIL_OFS_PA_DIR);

	// Sets win over a software write in the same cycle
	function setOrWrite;
		input set;
		input wr;
		input wbit;
		input cur;
		begin
			setOrWrite = set | (wr ? wbit : cur);
		end
	endfunction

	cail_sync u_sync
	(
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn ({secondCmpRaw, firstCmpRaw}),
		.syncOut (cmpSync)
	);

	wire cmpMismatch = (cmpSync != cmpLatch_r);
	// read race
	// A control access in the same cycle swallows the change, so no flag
	wire cmpSet = cmpMismatch && !(wrCmp || rdCmp);

	wire extSet = extIrqPin && !extPrev_r;
	wire pbSet  = (portBChangePins != pbPrev_r);
	wire t0Set  = timerZeroOvf;

	wire perReq = mainIrq_r[`CAIL_PERIPHERAL_IRQ_ENABLE_BIT] && cmpEnable_r && cmpFlag_r;
	wire srcReq = perReq
		|| (mainIrq_r[`CAIL_T0IE_BIT] && mainIrq_r[`CAIL_T0IF_BIT])
		|| (mainIrq_r[`CAIL_EXTIE_BIT] && mainIrq_r[`CAIL_EXTIF_BIT])
		|| (mainIrq_r[`CAIL_PBIE_BIT] && mainIrq_r[`CAIL_PBIF_BIT]);
	wire irqDue = srcReq && mainIrq_r[`CAIL_GIE_BIT];

	always @*
	begin
		mainIrq_nxt = mainIrq_r;
		if (wrMain)
		begin
			mainIrq_nxt = regWdata;
		end
		mainIrq_nxt[`CAIL_T0IF_BIT] = setOrWrite(t0Set, wrMain,
			regWdata[`CAIL_T0IF_BIT], mainIrq_r[`CAIL_T0IF_BIT]);
		mainIrq_nxt[`CAIL_EXTIF_BIT] = setOrWrite(extSet, wrMain,
			regWdata[`CAIL_EXTIF_BIT], mainIrq_r[`CAIL_EXTIF_BIT]);
		mainIrq_nxt[`CAIL_PBIF_BIT] = setOrWrite(pbSet, wrMain,
			regWdata[`CAIL_PBIF_BIT], mainIrq_r[`CAIL_PBIF_BIT]);
		if (state_r == ST_WAIT2 && cycEnd)
		begin
			mainIrq_nxt[`CAIL_GIE_BIT] = 1'b0;
		end
		if (retFromIrq)
		begin
			mainIrq_nxt[`CAIL_GIE_BIT] = 1'b1;
		end
	end

	always @*
	begin
		cmpFlag_nxt = setOrWrite(cmpSet, wrFlag,
			regWdata[`CAIL_CMP_FLAG_BIT], cmpFlag_r);
	end

	// latency sequencer
	// Sampled at a cycle end, then two whole cycles before the vector:
	// an event early in a cycle sees three, a late one just over two.
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
			begin
				if (cycEnd && irqDue && !gieDrop_r)
				begin
					state_nxt = ST_WAIT1;
				end
			end
			ST_WAIT1:
			begin
				if (cycEnd)
				begin
					state_nxt = ST_WAIT2;
				end
			end
			ST_WAIT2:
			begin
				if (cycEnd)
				begin
					state_nxt = ST_IDLE;
				end
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always @*
	begin
		rdMux = 8'h00;
		case (regAddr)
			`CAIL_OFS_CMP_CTRL:
			begin
				rdMux[`CAIL_CMP_OUT2_BIT] = cmpSync[1];
				rdMux[`CAIL_CMP_OUT1_BIT] = cmpSync[0];
				rdMux[`CAIL_CMP_MODE_HI:`CAIL_CMP_MODE_LO] = cmpMode_r;
			end
			`CAIL_OFS_PER_FLAG:
			begin
				rdMux[`CAIL_CMP_FLAG_BIT] = cmpFlag_r;
			end
			`CAIL_OFS_PER_EN:
			begin
				rdMux[`CAIL_CMP_FLAG_BIT] = cmpEnable_r;
			end
			`CAIL_OFS_MAIN_IRQ:
			begin
				rdMux = mainIrq_r;
			end
			`CAIL_OFS_PA_DIR:
			begin
				rdMux[`CAIL_PA3_BIT] = paDir_r[0];
				rdMux[`CAIL_PA4_BIT] = paDir_r[1];
			end
			default:
			begin
				rdMux = 8'h00;
			end
		endcase
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmpMode_r    <= `CAIL_RST_CMP_MODE;
			cmpLatch_r   <= 2'h0;
			cmpFlag_r    <= 1'b0;
			cmpEnable_r  <= 1'b0;
			mainIrq_r    <= `CAIL_RST_MAIN_IRQ;
			paDir_r      <= 2'h3;
			extPrev_r    <= 1'b0;
			pbPrev_r     <= 4'h0;
			qCnt_r       <= 2'h0;
			state_r      <= ST_IDLE;
			gieClrPend_r <= 1'b0;
			gieDrop_r    <= 1'b0;
			regRdata     <= 8'h00;
		end
		else
		begin
			if (wrCmp)
			begin
				cmpMode_r <= regWdata[`CAIL_CMP_MODE_HI:`CAIL_CMP_MODE_LO];
			end
			if (wrCmp || rdCmp)
			begin
				cmpLatch_r <= cmpSync;
			end
			cmpFlag_r <= cmpFlag_nxt;
			if (wrEn)
			begin
				cmpEnable_r <= regWdata[`CAIL_CMP_FLAG_BIT];
			end
			mainIrq_r <= mainIrq_nxt;
			if (wrDir)
			begin
				paDir_r <= {regWdata[`CAIL_PA4_BIT], regWdata[`CAIL_PA3_BIT]};
			end
			extPrev_r <= extIrqPin;
			pbPrev_r  <= portBChangePins;
			qCnt_r    <= qCnt_r + 2'h1;
			state_r   <= state_nxt;
			// remember software clear
			// Held until the cycle boundary, then blocks one whole cycle
			if (wrMain && !regWdata[`CAIL_GIE_BIT] && mainIrq_r[`CAIL_GIE_BIT])
			begin
				gieClrPend_r <= 1'b1;
			end
			else if (cycEnd)
			begin
				gieClrPend_r <= 1'b0;
			end
			if (cycEnd)
			begin
				gieDrop_r <= gieClrPend_r;
			end
			regRdata <= regRd ? rdMux : 8'h00;
		end
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			portAPin3Out <= 1'b0;
			portAPin3Oe  <= 1'b0;
			portAPin4Out <= 1'b0;
			portAPin4Oe  <= 1'b0;
			cmpPowerOn   <= 1'b0;
			intRefSelect <= 1'b0;
			allAnalog    <= 1'b1;
			qPhase       <= 2'h0;
			vectorLoad   <= 1'b0;
			vectorAddr   <= 13'h0000;
			pushReturn   <= 1'b0;
			forceNop     <= 1'b0;
			wakeUp       <= 1'b0;
		end
		else
		begin
			// raw output routing
			// One flop of delay is the price of a registered output
			if (cmpMode_r == `CAIL_MODE_PINOUT)
			begin
				portAPin3Out <= firstCmpRaw;
				portAPin4Out <= secondCmpRaw;
			end
			else
			begin
				portAPin3Out <= portADataPin3;
				portAPin4Out <= portADataPin4;
			end
			portAPin3Oe  <= !paDir_r[0];
			portAPin4Oe  <= !paDir_r[1];
			cmpPowerOn   <= (cmpMode_r != `CAIL_MODE_OFF)
				&& (cmpMode_r != `CAIL_MODE_RESET);
			intRefSelect <= (cmpMode_r == `CAIL_MODE_INTREF);
			allAnalog    <= (cmpMode_r == `CAIL_MODE_RESET);
			qPhase       <= qCnt_r;
			vectorLoad   <= (state_r == ST_WAIT2) && cycEnd;
			pushReturn   <= (state_r == ST_WAIT2) && cycEnd;
			vectorAddr   <= `CAIL_VECTOR_ADDR;
			forceNop     <= cycEnd && gieClrPend_r;
			// enabled source wakes regardless of global enable
			wakeUp       <= sleepMode && srcReq;
		end
	end

endmodule

/* File: cail_top_tb.sv */
`timescale 1ns/1ps
module cail_top_tb;
	logic        clk, rst_n, regWr, regRd, firstCmpRaw, secondCmpRaw, extIrqPin;
	logic        timerZeroOvf, sleepMode, retFromIrq, portAPin3Out, portAPin3Oe;
	logic        portAPin4Out, portAPin4Oe, cmpPowerOn, intRefSelect, allAnalog;
	logic        vectorLoad, pushReturn, forceNop, wakeUp, seen;
	logic        portADataPin3, portADataPin4;
	logic [2:0]  regAddr;
	logic [7:0]  regWdata, regRdata, d;
	logic [3:0]  portBChangePins;
	logic [1:0]  qPhase;
	logic [12:0] vectorAddr;
	int          fail_count, n_tests, n;
	cail_top cail_top_i (.clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.firstCmpRaw, .secondCmpRaw, .extIrqPin, .timerZeroOvf, .portBChangePins,
		.portADataPin3, .portADataPin4, .sleepMode, .retFromIrq,
		.portAPin3Out, .portAPin3Oe, .portAPin4Out, .portAPin4Oe, .cmpPowerOn,
		.intRefSelect, .allAnalog, .qPhase, .vectorLoad, .vectorAddr, .pushReturn,
		.forceNop, .wakeUp);
	cail_core_model cail_core_model_i (.clk, .rst_n, .vectorLoad, .pushReturn, .retFromIrq);
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task give_verdict;
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("FAIL %s exp %h got %h", nm, e, g);
			fail_count++;
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		regWr <= 1;
		regAddr <= a;
		regWdata <= v;
		@(posedge clk);
		regWr <= 0;
	endtask
	task rd(input logic [2:0] a);
		@(posedge clk);
		regRd <= 1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 0;
		#1 d = regRdata;
	endtask
	// Flag stays set while outputs differ from the copy latched at the last control read or write
	task t_cmp_flag;
		wr(0, 8'h00);
		wr(1, 8'h00);
		firstCmpRaw <= 1;
		cyc(6);
		rd(1); chk("flag on change", 8'h40, d);
		rd(0); chk("ctrl outputs", 8'h40, d);
		wr(1, 8'h00);
		rd(1); chk("flag cleared", 8'h00, d);
		wr(1, 8'h40);
		rd(1); chk("flag soft set", 8'h40, d);
		@(posedge clk);
		secondCmpRaw <= 1;
		cyc(6);
		wr(1, 8'h00);
		rd(1); chk("flag kept", 8'h40, d);
		wr(0, 8'h00);
		rd(0); chk("outputs read only", 8'hC0, d);
		wr(1, 8'h00);
		rd(1); chk("flag after access", 8'h00, d);
		rd(5); chk("unmapped read", 8'h00, d);
	endtask
	// A change that reaches the synced outputs in the read cycle is swallowed
	task t_read_race;
		wr(1, 8'h00);
		firstCmpRaw <= 0;
		cyc(1);
		rd(0); chk("race outputs", 8'h80, d);
		rd(1); chk("race flag", 8'h00, d);
	endtask
	task t_modes;
		logic [2:0] m[4];
		logic [2:0] e[4];
		m = '{3'h2, 3'h6, 3'h7, 3'h0};
		e = '{3'h6, 3'h2, 3'h0, 3'h1};
		wr(4, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr(0, {5'h00, m[i]});
			cyc(3);
			chk("mode outputs", {5'h00, e[i]}, {5'h00, intRefSelect, cmpPowerOn, allAnalog});
			if (m[i] == 3'h6)
			begin
				firstCmpRaw <= 0;
				cyc(3);
				chk("pins", 8'h07, {4'h0, portAPin3Out, portAPin4Out, portAPin3Oe, portAPin4Oe});
				wr(4, 8'h18);
				cyc(3);
				chk("pins off", 8'h00, {6'h00, portAPin3Oe, portAPin4Oe});
			end
			else
			begin
				chk("pins data", 8'h03, {6'h00, portAPin3Out, portAPin4Out});
			end
		end
		rd(0);
	endtask
	task t_flags;
		wr(3, 8'h00);
		timerZeroOvf <= 1;
		extIrqPin <= 1;
		portBChangePins <= 4'h5;
		@(posedge clk);
		timerZeroOvf <= 0;
		cyc(3);
		rd(3); chk("flags no enable", 8'h07, d);
		wr(3, 8'h00);
		extIrqPin <= 0;
	endtask
	task t_wake;
		wr(0, 8'h02);
		wr(2, 8'h40);
		wr(3, 8'h40);
		sleepMode <= 1;
		wr(1, 8'h40);
		seen = 0;
		repeat (16)
		begin
			@(posedge clk);
			seen |= vectorLoad;
		end
		chk("no vector", 8'h00, {7'h00, seen});
		chk("wake", 8'h01, {7'h00, wakeUp});
		chk("powered in sleep", 8'h01, {7'h00, cmpPowerOn});
		rd(0); chk("mode kept", 8'h02, d & 8'h07);
		@(posedge clk);
		sleepMode <= 0;
		wr(1, 8'h00);
		wr(2, 8'h00);
	endtask
	task t_irq;
		wr(3, 8'h90);
		extIrqPin <= 1;
		n = 0;
		do
		begin
			@(posedge clk);
			#1 n++;
		end
		while (!vectorLoad && n < 40);
		chk("latency ok", 8'h01, {7'h00, n >= 8 && n <= 16});
		rd(3); chk("gie cleared", 8'h12, d);
		// service clears its flag before returning
		wr(3, 8'h10);
		extIrqPin <= 0;
		n = 0;
		while (!retFromIrq)
		begin
			@(posedge clk);
			if (++n > 60)
			begin
				fail_count++;
				give_verdict();
			end
		end
		cyc(2);
		rd(3); chk("gie back", 8'h90, d);
		wr(3, 8'h00);
		seen = 0;
		repeat (8)
		begin
			@(posedge clk);
			seen |= forceNop;
		end
		chk("nop after clear", 8'h01, {7'h00, seen});
	endtask
	initial
	begin
		{rst_n, regWr, regRd, firstCmpRaw, secondCmpRaw, extIrqPin} = 0;
		{timerZeroOvf, sleepMode, regAddr, regWdata, portBChangePins} = 0;
		{portADataPin3, portADataPin4} = 2'h3;
		repeat (20) @(posedge clk);
		rst_n <= 1;
		#1 chk("reset pins", 8'h08, {4'h0, allAnalog, cmpPowerOn, portAPin3Oe, portAPin4Oe});
		rd(3); chk("main reset", 8'h00, d);
		rd(0); chk("mode reset", 8'h00, d & 8'h07);
		t_cmp_flag();
		t_read_race();
		t_modes();
		t_flags();
		t_wake();
		t_irq();
		give_verdict();
	end
endmodule
